// [tmf_top.sv]
// Operating-mode state machine of a bus transceiver with an APB status port.
`timescale 1ns/1ps

module tmf_top
#(
  parameter logic [tmf_pkg::CNT_W-1:0] GTS_HOLD_CYC = tmf_pkg::GTS_HOLD_CYC,
  parameter logic [tmf_pkg::CNT_W-1:0] CORE_DET_CYC = tmf_pkg::CORE_DET_CYC,
  parameter logic [tmf_pkg::CNT_W-1:0] CORE_REC_CYC = tmf_pkg::CORE_REC_CYC,
  parameter logic [tmf_pkg::CNT_W-1:0] BAT_REC_CYC = tmf_pkg::BAT_REC_CYC
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_standby_select_low_pin,
  input wire logic i_normal_select_pin,
  input wire logic i_io_supply_low,
  input wire logic i_battery_low,
  input wire logic i_core_supply_low,
  input wire logic i_internal_logic_supply_low,
  input wire logic i_wake_detect,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [tmf_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [5:0] o_mode,
  output logic o_wake_flag,
  output logic o_power_on_flag,
  output logic o_io_supply_low_flag,
  output logic o_battery_low_flag,
  output logic o_core_supply_low_flag,
  output logic o_external_regulator_switch,
  output logic o_external_regulator_switch_oe
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Saturating duration counter; clears whenever its condition drops.
  function automatic logic [tmf_pkg::CNT_W-1:0] count_up
  (
    input logic run,
    input logic [tmf_pkg::CNT_W-1:0] cnt,
    input logic [tmf_pkg::CNT_W-1:0] lim
  );
    logic [tmf_pkg::CNT_W-1:0] res;
    res = '0;
    if (run)
    begin
      res = (cnt >= lim) ? cnt : tmf_pkg::CNT_W'(cnt + 1'b1);
    end
    return res;
  endfunction : count_up

  // Mode requested by the two host pins.
  function automatic tmf_pkg::tmf_mode_t pin_mode
  (
    input logic standby_sel_n,
    input logic en
  );
    tmf_pkg::tmf_mode_t res;
    res = tmf_pkg::MODE_STANDBY;
    case ({standby_sel_n, en})
      2'b11: res = tmf_pkg::MODE_NORMAL;
      2'b10: res = tmf_pkg::MODE_RXONLY;
      2'b01: res = tmf_pkg::MODE_GOSLEEP;
      default: res = tmf_pkg::MODE_STANDBY;
    endcase
    return res;
  endfunction : pin_mode

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  tmf_sync_if sync_bus ();

  assign sync_bus.raw = {i_wake_detect, i_internal_logic_supply_low, i_core_supply_low,
                         i_battery_low, i_io_supply_low, i_normal_select_pin,
                         i_standby_select_low_pin};

  tmf_pin_sync u_sync
  (
    .i_clock (i_clock),
    .i_rstn (i_rstn),
    .sync (sync_bus.syncer)
  );

  wire standby_sel_n = sync_bus.clean[tmf_pkg::IN_STANDBY_SEL_N];
  wire en = sync_bus.clean[tmf_pkg::IN_EN];
  wire io_low = sync_bus.clean[tmf_pkg::IN_IO_LOW];
  wire bat_low = sync_bus.clean[tmf_pkg::IN_BAT_LOW];
  wire core_low = sync_bus.clean[tmf_pkg::IN_CORE_LOW];
  wire logic_low = sync_bus.clean[tmf_pkg::IN_LOGIC_LOW];
  wire wake_in = sync_bus.clean[tmf_pkg::IN_WAKE];

  // ==========================================================================
  // State
  // ==========================================================================
  tmf_pkg::tmf_mode_t mode_q;
  tmf_pkg::tmf_mode_t mode_d;
  logic wake_q;
  logic pon_q;
  logic io_flag_q;
  logic bat_flag_q;
  logic core_flag_q;
  logic wake_prev_q;
  logic io_prev_q;
  logic bat_prev_q;
  logic [tmf_pkg::CNT_W-1:0] gts_cnt_q;
  logic [tmf_pkg::CNT_W-1:0] core_det_q;
  logic [tmf_pkg::CNT_W-1:0] core_rec_q;
  logic [tmf_pkg::CNT_W-1:0] bat_rec_q;
  logic reg_sw_q;
  logic reg_sw_oe_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic uv_exit;
  logic pon_set;

  // ==========================================================================
  // Events and timers
  // ==========================================================================
  wire wake_rise = wake_in & ~wake_prev_q;
  wire io_rise = io_low & ~io_prev_q;
  wire bat_rise = bat_low & ~bat_prev_q;
  wire gts_done = (gts_cnt_q >= GTS_HOLD_CYC);
  wire core_det_hit = core_low & (core_det_q == CORE_DET_CYC - 1'b1);
  wire core_rec_done = ~core_low & (core_rec_q >= CORE_REC_CYC);
  wire bat_rec_done = ~bat_low & (bat_rec_q >= BAT_REC_CYC);
  wire in_active = (mode_q == tmf_pkg::MODE_NORMAL) | (mode_q == tmf_pkg::MODE_RXONLY);
  wire in_sleep = (mode_q == tmf_pkg::MODE_SLEEP);
  wire any_uv = io_flag_q | bat_flag_q | core_flag_q;

  tmf_pkg::tmf_mode_t pin_tgt;
  assign pin_tgt = pin_mode(standby_sel_n, en);
  wire tgt_active = (pin_tgt == tmf_pkg::MODE_NORMAL) | (pin_tgt == tmf_pkg::MODE_RXONLY);

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire apb_setup = i_psel & ~i_penable & ~pready_q;
  wire apb_done = i_psel & i_penable & pready_q;
  wire hit_ctrl = (i_paddr == tmf_pkg::CTRL_OFFSET);
  wire hit_stat = (i_paddr == tmf_pkg::STATUS_OFFSET);
  wire ctrl_wr = apb_done & i_pwrite & hit_ctrl;
  wire sw_clr_pon = ctrl_wr & i_pwdata[tmf_pkg::CTRL_CLR_PON_BIT];
  wire sw_clr_wake = ctrl_wr & i_pwdata[tmf_pkg::CTRL_CLR_WAKE_BIT];

  logic [31:0] status_word;
  always_comb
  begin
    status_word = tmf_pkg::READ_ZERO;
    status_word[tmf_pkg::STAT_MODE_LSB +: 6] = mode_q;
    status_word[tmf_pkg::STAT_WAKE_BIT] = wake_q;
    status_word[tmf_pkg::STAT_PON_BIT] = pon_q;
    status_word[tmf_pkg::STAT_IO_BIT] = io_flag_q;
    status_word[tmf_pkg::STAT_BAT_BIT] = bat_flag_q;
    status_word[tmf_pkg::STAT_CORE_BIT] = core_flag_q;
  end
  wire [31:0] rd_word = (hit_stat & ~i_pwrite) ? status_word : tmf_pkg::READ_ZERO;

  // ==========================================================================
  // Mode transitions
  // ==========================================================================
  always_comb
  begin
    mode_d = mode_q;
    uv_exit = 1'b0;
    pon_set = 1'b0;
    if (logic_low)
    begin
      mode_d = tmf_pkg::MODE_POWEROFF;
    end
    else
    begin
      case (mode_q)
        tmf_pkg::MODE_POWEROFF:
        begin
          if (bat_rec_done)
          begin
            mode_d = tmf_pkg::MODE_STANDBY;
            pon_set = 1'b1;
          end
        end
        tmf_pkg::MODE_SLEEP:
        begin
          if (wake_rise)
          begin
            // Every wake exit lands in Standby; pins act from there.
            mode_d = tmf_pkg::MODE_STANDBY;
          end
          else if (standby_sel_n & ~io_flag_q & ~bat_flag_q)
          begin
            mode_d = (tgt_active & core_flag_q) ? tmf_pkg::MODE_STANDBY : pin_tgt;
          end
        end
        tmf_pkg::MODE_NORMAL,
        tmf_pkg::MODE_RXONLY,
        tmf_pkg::MODE_STANDBY,
        tmf_pkg::MODE_GOSLEEP:
        begin
          if (io_flag_q | bat_flag_q)
          begin
            mode_d = tmf_pkg::MODE_SLEEP;
            uv_exit = 1'b1;
          end
          else if (core_flag_q & in_active)
          begin
            mode_d = tmf_pkg::MODE_STANDBY;
            uv_exit = 1'b1;
          end
          else if (wake_rise & ~in_active)
          begin
            // The wake clears the core flag at this same edge.
            mode_d = pin_tgt;
          end
          else if ((mode_q == tmf_pkg::MODE_GOSLEEP) & ~standby_sel_n & gts_done & ~wake_q)
          begin
            mode_d = tmf_pkg::MODE_SLEEP;
          end
          else if (tgt_active & core_flag_q)
          begin
            mode_d = mode_q;
          end
          else if ((mode_q == tmf_pkg::MODE_NORMAL) & pon_q)
          begin
            mode_d = mode_q;
          end
          else
          begin
            mode_d = pin_tgt;
          end
        end
        default:
        begin
          mode_d = tmf_pkg::MODE_RESET;
        end
      endcase
    end
  end

  // ==========================================================================
  // Flags
  // ==========================================================================
  // Every flag lets a set in the same cycle win over its clear.
  wire wake_d = wake_rise | (wake_q & ~uv_exit & ~sw_clr_wake);
  wire pon_d = pon_set | (pon_q & ~sw_clr_pon);
  wire io_d = io_rise | (io_flag_q & io_low & ~wake_rise);
  wire bat_d = bat_rise | (bat_flag_q & bat_low & ~wake_rise);
  wire core_d = core_det_hit | (core_flag_q & ~core_rec_done & ~wake_rise);
  wire sw_on_d = (mode_d != tmf_pkg::MODE_SLEEP) & (mode_d != tmf_pkg::MODE_POWEROFF);

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mode_q <= tmf_pkg::MODE_RESET;
      wake_q <= 1'b0;
      pon_q <= 1'b0;
      io_flag_q <= 1'b0;
      bat_flag_q <= 1'b0;
      core_flag_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      wake_q <= wake_d;
      pon_q <= pon_d;
      io_flag_q <= io_d;
      bat_flag_q <= bat_d;
      core_flag_q <= core_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wake_prev_q <= 1'b0;
      io_prev_q <= 1'b0;
      bat_prev_q <= 1'b0;
      gts_cnt_q <= '0;
      core_det_q <= '0;
      core_rec_q <= '0;
      bat_rec_q <= '0;
    end
    else
    begin
      wake_prev_q <= wake_in;
      io_prev_q <= io_low;
      bat_prev_q <= bat_low;
      gts_cnt_q <= count_up(mode_q == tmf_pkg::MODE_GOSLEEP, gts_cnt_q, GTS_HOLD_CYC);
      core_det_q <= count_up(core_low, core_det_q, CORE_DET_CYC);
      core_rec_q <= count_up(~core_low, core_rec_q, CORE_REC_CYC);
      bat_rec_q <= count_up(~bat_low, bat_rec_q, BAT_REC_CYC);
    end
  end

  // ==========================================================================
  // Outputs and APB slave
  // ==========================================================================
  // Registered on the next mode so the pin follows the mode without lag.
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      reg_sw_q <= 1'b0;
      reg_sw_oe_q <= 1'b0;
    end
    else
    begin
      reg_sw_q <= sw_on_d;
      reg_sw_oe_q <= sw_on_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= tmf_pkg::READ_ZERO;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~hit_ctrl & ~hit_stat;
      prdata_q <= apb_setup ? rd_word : tmf_pkg::READ_ZERO;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_mode = mode_q;
  assign o_wake_flag = wake_q;
  assign o_power_on_flag = pon_q;
  assign o_io_supply_low_flag = io_flag_q;
  assign o_battery_low_flag = bat_flag_q;
  assign o_core_supply_low_flag = core_flag_q;
  assign o_external_regulator_switch = reg_sw_q;
  assign o_external_regulator_switch_oe = reg_sw_oe_q;

endmodule : tmf_top

// [tmf_pkg.sv]
// Package with constants and types of the transceiver mode state machine.
package tmf_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W = 20;
  // Hold time of Go-to-sleep before Sleep is entered.
  localparam int GTS_HOLD_NS = 50000;
  localparam logic [CNT_W-1:0] GTS_HOLD_CYC =
    CNT_W'((GTS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Core supply undervoltage detection time.
  localparam int CORE_DET_NS = 100000;
  localparam logic [CNT_W-1:0] CORE_DET_CYC =
    CNT_W'((CORE_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Core supply recovery time.
  localparam int CORE_REC_NS = 1000000;
  localparam logic [CNT_W-1:0] CORE_REC_CYC =
    CNT_W'((CORE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Battery supply recovery time.
  localparam int BAT_REC_NS = 1000000;
  localparam logic [CNT_W-1:0] BAT_REC_CYC =
    CNT_W'((BAT_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Synchronised inputs
  // ==========================================================================
  localparam int SYNC_W = 7;
  localparam int IN_STANDBY_SEL_N = 0;
  localparam int IN_EN = 1;
  localparam int IN_IO_LOW = 2;
  localparam int IN_BAT_LOW = 3;
  localparam int IN_CORE_LOW = 4;
  localparam int IN_LOGIC_LOW = 5;
  localparam int IN_WAKE = 6;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_CLR_PON_BIT = 0;
  localparam int CTRL_CLR_WAKE_BIT = 1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_WAKE_BIT = 8;
  localparam int STAT_PON_BIT = 9;
  localparam int STAT_IO_BIT = 10;
  localparam int STAT_BAT_BIT = 11;
  localparam int STAT_CORE_BIT = 12;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [5:0] {
    MODE_NORMAL = 6'h01,
    MODE_RXONLY = 6'h02,
    MODE_STANDBY = 6'h04,
    MODE_GOSLEEP = 6'h08,
    MODE_SLEEP = 6'h10,
    MODE_POWEROFF = 6'h20
  } tmf_mode_t;

  localparam tmf_mode_t MODE_RESET = MODE_POWEROFF;

endpackage : tmf_pkg

// [tmf_sync_if.sv]
// Interface carrying raw asynchronous inputs and their filtered levels.
`timescale 1ns/1ps
interface tmf_sync_if;
  logic [tmf_pkg::SYNC_W-1:0] raw;
  logic [tmf_pkg::SYNC_W-1:0] clean;
  modport syncer (input raw, output clean);
  modport user (output raw, input clean);
endinterface : tmf_sync_if

// [tmf_pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/1ps
module tmf_pin_sync
(
  input wire logic i_clock,
  input wire logic i_rstn,
  tmf_sync_if.syncer sync
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [tmf_pkg::SYNC_W-1:0] st1_q;
  logic [tmf_pkg::SYNC_W-1:0] st2_q;
  logic [tmf_pkg::SYNC_W-1:0] st3_q;
  logic [tmf_pkg::SYNC_W-1:0] clean_q;
  logic [tmf_pkg::SYNC_W-1:0] agree;
  logic [tmf_pkg::SYNC_W-1:0] clean_d;

  // A single glitch seen by one stage only never reaches the mode logic.
  assign agree = ~(st2_q ^ st3_q);
  assign clean_d = (agree & st3_q) | (~agree & clean_q);

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
      clean_q <= '0;
    end
    else
    begin
      st1_q <= sync.raw;
      st2_q <= st1_q;
      st3_q <= st2_q;
      clean_q <= clean_d;
    end
  end

  assign sync.clean = clean_q;

endmodule : tmf_pin_sync

// [tmf_host_model.sv]
// Host controller model that drives the two mode pins.
`timescale 1ns/1ps
module tmf_host_model
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [1:0] i_req,
  input wire logic i_glitch,
  output logic o_standby_sel_n,
  output logic o_en
);
  // ====================
  // Pin drive
  // ====================
  // Pins move just after an edge; a glitch flips the standby pin for every cycle that i_glitch is held high.
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_standby_sel_n <= 1'b0;
      o_en <= 1'b0;
    end
    else
    begin
      o_standby_sel_n <= i_req[1] ^ i_glitch;
      o_en <= i_req[0];
    end
  end
endmodule : tmf_host_model

// [tmf_monitor.sv]
// Checker of the mode state machine ports.
`timescale 1ns/1ps
module tmf_monitor
#(
  parameter logic [tmf_pkg::CNT_W-1:0] GTS_HOLD_CYC = 20'h0_0004
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_internal_logic_supply_low,
  input wire logic [5:0] o_mode,
  input wire logic o_wake_flag,
  input wire logic o_power_on_flag,
  input wire logic o_io_supply_low_flag,
  input wire logic o_battery_low_flag,
  input wire logic o_core_supply_low_flag,
  input wire logic o_external_regulator_switch,
  input wire logic o_external_regulator_switch_oe
);
  // ====================
  // Helpers
  // ====================
  wire logic m_nor = o_mode == tmf_pkg::MODE_NORMAL;
  wire logic m_rx = o_mode == tmf_pkg::MODE_RXONLY;
  wire logic m_stb = o_mode == tmf_pkg::MODE_STANDBY;
  wire logic m_gts = o_mode == tmf_pkg::MODE_GOSLEEP;
  wire logic m_slp = o_mode == tmf_pkg::MODE_SLEEP;
  wire logic m_off = o_mode == tmf_pkg::MODE_POWEROFF;
  logic [tmf_pkg::CNT_W-1:0] gts_cnt_q;
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      gts_cnt_q <= '0;
    else
      gts_cnt_q <= m_gts ? gts_cnt_q + 1'b1 : '0;
  end
  // ====================
  // Assertions
  // ====================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_wake_in_sleep;
    m_slp ##1 $rose(o_wake_flag);
  endsequence
  a_switch_on: assert property (
    (m_nor | m_rx | m_stb) |-> o_external_regulator_switch && o_external_regulator_switch_oe)
    else $error("Regulator switch not driven high.");
  a_switch_float: assert property ((m_slp | m_off) |-> !o_external_regulator_switch_oe)
    else $error("Regulator switch driven in sleep.");
  a_logic_off: assert property (i_internal_logic_supply_low [*7] |-> m_off)
    else $error("No power off on low logic supply.");
  a_gts_hold: assert property (
    $past(m_gts) && m_slp && !o_io_supply_low_flag && !o_battery_low_flag
    |-> gts_cnt_q >= GTS_HOLD_CYC && !$past(o_wake_flag))
    else $error("Sleep entered too early.");
  a_wake_clr_uv: assert property ($rose(o_wake_flag) |-> !o_io_supply_low_flag &&
    !o_battery_low_flag && !o_core_supply_low_flag)
    else $error("Wake left a supply flag set.");
  a_sleep_via_stby: assert property (s_wake_in_sleep |-> m_stb)
    else $error("Wake from sleep skipped standby.");
  a_core_blocks: assert property (
    o_core_supply_low_flag && $past(o_core_supply_low_flag) |-> !(m_nor | m_rx))
    else $error("Normal group reached under core low.");
  a_uv_sleep: assert property (
    ($rose(o_io_supply_low_flag) || $rose(o_battery_low_flag)) && !m_off && !m_slp
    |=> m_slp && !o_wake_flag)
    else $error("Supply low did not force sleep.");
  a_pon_exit: assert property ($past(m_off) && m_stb |-> o_power_on_flag)
    else $error("Power on flag not set.");
  a_normal_pon: assert property (
    $past(m_nor) && (m_rx | m_gts | m_stb) && !o_core_supply_low_flag
    |-> !$past(o_power_on_flag))
    else $error("Normal left with power on flag.");
endmodule : tmf_monitor

bind tmf_top tmf_monitor #(.GTS_HOLD_CYC(GTS_HOLD_CYC)) tmf_monitor_i (
  .i_clock(i_clock),
  .i_rstn(i_rstn),
  .i_internal_logic_supply_low(i_internal_logic_supply_low),
  .o_mode(o_mode),
  .o_wake_flag(o_wake_flag),
  .o_power_on_flag(o_power_on_flag),
  .o_io_supply_low_flag(o_io_supply_low_flag),
  .o_battery_low_flag(o_battery_low_flag),
  .o_core_supply_low_flag(o_core_supply_low_flag),
  .o_external_regulator_switch(o_external_regulator_switch),
  .o_external_regulator_switch_oe(o_external_regulator_switch_oe)
);

// [tb_top.sv]
// Self-checking testbench of the transceiver mode state machine.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] req = 2'b00;
  logic glitch = 1'b0;
  logic io_low = 1'b0;
  logic bat_low = 1'b0;
  logic core_low = 1'b0;
  logic lgc_low = 1'b0;
  logic wake = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [5:0] mode;
  logic pready, pslverr, err, sel_n, en, wflag, pon, iof, batf, coref, sw, sw_oe;
  int error_cnt = 0;
  int n_tests = 0;
  // Each row packs the two pins above the one-hot mode they should select.
  logic [7:0] rows [17] = '{8'h82, 8'h04, 8'h82, 8'hC1, 8'h04, 8'hC1, 8'h48, 8'hC1, 8'h04,
    8'h48, 8'h04, 8'h82, 8'h48, 8'h50, 8'hC1, 8'h48, 8'h50};

  initial
  begin
    forever #20 clk = ~clk;
  end

  tmf_host_model tmf_host_model_i (.i_clock(clk), .i_rstn(rstn), .i_req(req),
    .i_glitch(glitch), .o_standby_sel_n(sel_n), .o_en(en));

  tmf_top #(.GTS_HOLD_CYC(20'h0_0014), .CORE_DET_CYC(20'h0_0004),
    .CORE_REC_CYC(20'h0_0004), .BAT_REC_CYC(20'h0_0004)) tmf_top_i (
    .i_clock(clk), .i_rstn(rstn), .i_standby_select_low_pin(sel_n), .i_normal_select_pin(en),
    .i_io_supply_low(io_low), .i_battery_low(bat_low), .i_core_supply_low(core_low),
    .i_internal_logic_supply_low(lgc_low), .i_wake_detect(wake), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_mode(mode), .o_wake_flag(wflag),
    .o_power_on_flag(pon), .o_io_supply_low_flag(iof), .o_battery_low_flag(batf),
    .o_core_supply_low_flag(coref), .o_external_regulator_switch(sw),
    .o_external_regulator_switch_oe(sw_oe));

  // ====================
  // Tasks
  // ====================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_mode(input logic [5:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 80)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(32'(mode), 32'(m));
  endtask : wait_mode

  // The master holds every request signal until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(pready), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask : apb

  task automatic print_verdict;
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ====================
  // Sequence
  // ====================
  initial
  begin
    repeat (11) @(posedge clk);
    #1;
    chk(32'({mode, wflag, pon, iof, batf, coref, sw_oe}), 32'h0000_0800);
    @(posedge clk);
    rstn <= 1'b1;
    req <= 2'b11;
    wait_mode(tmf_pkg::MODE_STANDBY);
    chk(32'(pon), 32'h0000_0001);
    wait_mode(tmf_pkg::MODE_NORMAL);
    @(posedge clk);
    req <= 2'b10;
    repeat (12) @(posedge clk);
    #1;
    chk(32'({mode, sw, sw_oe}), 32'h0000_0007);
    apb(1'b1, tmf_pkg::CTRL_OFFSET, 32'h0000_0001);
    chk(32'(pon), 32'h0000_0000);
    wait_mode(tmf_pkg::MODE_RXONLY);
    for (int i = 0; i < 17; i++)
    begin
      @(posedge clk);
      req <= rows[i][7:6];
      wait_mode(rows[i][5:0]);
    end
    chk(32'({sw, sw_oe}), 32'h0000_0000);
    @(posedge clk);
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(32'(mode), 32'(tmf_pkg::MODE_SLEEP));
    @(posedge clk);
    wake <= 1'b1;
    wait_mode(tmf_pkg::MODE_STANDBY);
    @(posedge clk);
    #1;
    chk(32'(mode), 32'(tmf_pkg::MODE_GOSLEEP));
    repeat (30) @(posedge clk);
    #1;
    chk(32'({mode, wflag}), 32'h0000_0011);
    @(posedge clk);
    wake <= 1'b0;
    io_low <= 1'b1;
    wait_mode(tmf_pkg::MODE_SLEEP);
    chk(32'({iof, wflag}), 32'h0000_0002);
    @(posedge clk);
    wake <= 1'b1;
    wait_mode(tmf_pkg::MODE_STANDBY);
    chk(32'(iof), 32'h0000_0000);
    wait_mode(tmf_pkg::MODE_GOSLEEP);
    @(posedge clk);
    io_low <= 1'b0;
    wake <= 1'b0;
    apb(1'b1, tmf_pkg::CTRL_OFFSET, 32'h0000_0002);
    chk(32'(wflag), 32'h0000_0000);
    wait_mode(tmf_pkg::MODE_SLEEP);
    @(posedge clk);
    req <= 2'b11;
    wait_mode(tmf_pkg::MODE_NORMAL);
    @(posedge clk);
    bat_low <= 1'b1;
    wait_mode(tmf_pkg::MODE_SLEEP);
    chk(32'(batf), 32'h0000_0001);
    @(posedge clk);
    bat_low <= 1'b0;
    wait_mode(tmf_pkg::MODE_NORMAL);
    @(posedge clk);
    core_low <= 1'b1;
    wait_mode(tmf_pkg::MODE_STANDBY);
    repeat (15) @(posedge clk);
    apb(1'b0, tmf_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0000_1004);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    @(posedge clk);
    core_low <= 1'b0;
    wait_mode(tmf_pkg::MODE_NORMAL);
    chk(32'(coref), 32'h0000_0000);
    @(posedge clk);
    lgc_low <= 1'b1;
    wait_mode(tmf_pkg::MODE_POWEROFF);
    chk(32'({sw, sw_oe}), 32'h0000_0000);
    repeat (3) @(posedge clk);
    lgc_low <= 1'b0;
    wait_mode(tmf_pkg::MODE_STANDBY);
    chk(32'(pon), 32'h0000_0001);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(mode), 32'(tmf_pkg::MODE_POWEROFF));
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({mode, pon, sw_oe}), 32'h0000_0080);
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run of a few hundred cycles.
  initial
  begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule : tb_top
